// [shared/sfc_pkg.sv]
// constants, carrier types and decode helpers for the setting-command decoder
package sfc_pkg;

  // opcodes
  localparam logic [7:0] WRITE_LATCH_SET_CMD      = 8'h06;
  localparam logic [7:0] WRITE_LATCH_CLEAR_CMD    = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD          = 8'h05;
  localparam logic [7:0] CONFIG_READ_CMD          = 8'h15;
  localparam logic [7:0] STATUS_CONFIG_WRITE_CMD  = 8'h01;
  localparam logic [7:0] BLOCK_PROTECT_SELECT_CMD = 8'h68;
  localparam logic [7:0] QUAD_CMD_MODE_ENTER      = 8'h35;
  localparam logic [7:0] QUAD_CMD_MODE_EXIT       = 8'hf5;
  localparam logic [7:0] SUSPEND_CMD              = 8'hb0;
  localparam logic [7:0] RESUME_CMD               = 8'h30;
  localparam logic [7:0] DEEP_SLEEP_ENTER_CMD     = 8'hb9;
  localparam logic [7:0] DEEP_SLEEP_RELEASE_CMD   = 8'hab;
  localparam logic [7:0] BURST_LENGTH_SET_CMD     = 8'hc0;
  localparam logic [7:0] FASTBOOT_READ_CMD        = 8'h16;
  localparam logic [7:0] FASTBOOT_WRITE_CMD       = 8'h17;
  localparam logic [7:0] FASTBOOT_ERASE_CMD       = 8'h18;

  // data byte counts
  localparam logic [2:0] FB_WRITE_BYTES = 3'h4;
  localparam logic [2:0] SR_ONLY_BYTES  = 3'h1;
  localparam logic [2:0] SR_CFG_BYTES   = 3'h2;
  localparam int         FB_BYTES       = 4;

  // bus register offsets
  localparam logic [7:0] ADR_STATUS   = 8'h00;
  localparam logic [7:0] ADR_CONFIG   = 8'h04;
  localparam logic [7:0] ADR_MODE     = 8'h08;
  localparam logic [7:0] ADR_FASTBOOT = 8'h0c;
  localparam logic [7:0] ADR_CTRL     = 8'h10;

  // field positions and reset values
  localparam int         QUAD_ENABLE_POS = 4; // bit 6 of status, in [7:2]
  localparam int         CTRL_BUSY_POS   = 0;
  localparam logic [5:0] STATUS_HI_RST   = 6'h00;
  localparam logic [7:0] CONFIG_RST      = 8'h00;
  localparam logic [7:0] BURST_RST       = 8'h00;
  localparam logic [7:0] FB_BYTE_RST     = 8'hff;
  localparam logic [7:0] IDLE_BYTE       = 8'hff;

  typedef enum logic [1:0] {
    ST_OPCODE   = 2'b00,
    ST_DATA_IN  = 2'b01,
    ST_DATA_OUT = 2'b10,
    ST_IGNORE   = 2'b11
  } sfc_state_t;

  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] sio;
  } sfc_pins_t;

  typedef struct packed {
    logic block_protect;
    logic suspended;
    logic deep_sleep;
    logic four_line;
  } sfc_mode_t;

  // true when the opcode exists in the present command mode
  function automatic logic cmd_defined(input logic [7:0] op,
                                       input logic       four);
    case (op)
      WRITE_LATCH_SET_CMD, WRITE_LATCH_CLEAR_CMD, STATUS_READ_CMD,
      CONFIG_READ_CMD, STATUS_CONFIG_WRITE_CMD, BLOCK_PROTECT_SELECT_CMD,
      SUSPEND_CMD, RESUME_CMD, DEEP_SLEEP_ENTER_CMD,
      DEEP_SLEEP_RELEASE_CMD, BURST_LENGTH_SET_CMD: cmd_defined = 1'h1;
      QUAD_CMD_MODE_ENTER, FASTBOOT_READ_CMD, FASTBOOT_WRITE_CMD,
      FASTBOOT_ERASE_CMD: cmd_defined = !four;
      QUAD_CMD_MODE_EXIT: cmd_defined = four;
      default: cmd_defined = 1'h0;
    endcase
  endfunction : cmd_defined

  // opcodes that shift data out of the device
  function automatic logic cmd_is_read(input logic [7:0] op);
    cmd_is_read = (op == STATUS_READ_CMD) || (op == CONFIG_READ_CMD) ||
                  (op == FASTBOOT_READ_CMD);
  endfunction : cmd_is_read

  // last clock edge of a byte: eight edges on one line, two on four
  function automatic logic byte_done(input logic [2:0] cnt,
                                     input logic       four);
    byte_done = four ? (cnt == 3'h1) : (cnt == 3'h7);
  endfunction : byte_done

endpackage : sfc_pkg

// [hdl/sfc_fb_mem.sv]
// fast-boot register storage with registered byte and word read ports
`timescale 1ns/10ps
module sfc_fb_mem #(
  parameter int NBYTES = 4,
  parameter int IDX_W  = 2
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  wr_en,
  input  wire logic [8*NBYTES-1:0]   wr_word,
  input  wire logic                  erase,
  input  wire logic [IDX_W-1:0]      rd_idx,
  output logic      [7:0]            rd_byte_ff,
  output logic      [8*NBYTES-1:0]   word_ff
);

  logic [7:0] mem_ff [NBYTES];

  // byte 0 is the first byte on the wire, kept in the top of the word
  always_ff @(posedge clk) begin : store
    for (int i = 0; i < NBYTES; i++) begin
      if (rst || erase) begin
        mem_ff[i] <= sfc_pkg::FB_BYTE_RST;
      end else if (wr_en) begin
        mem_ff[i] <= wr_word[8*(NBYTES-1-i) +: 8];
      end
    end
  end

  // registered reads; one cycle is far shorter than a link half period
  always_ff @(posedge clk) begin : readout
    if (rst) begin
      rd_byte_ff <= 8'h00;
      word_ff    <= '1;
    end else begin
      rd_byte_ff <= mem_ff[rd_idx];
      for (int i = 0; i < NBYTES; i++) begin
        word_ff[8*(NBYTES-1-i) +: 8] <= mem_ff[i];
      end
    end
  end

endmodule : sfc_fb_mem

// [hdl/sfc_cmd_decoder.sv]
// serial flash setting-command decoder with wishbone status registers
// Operation
// - opcode 06 sets write enable latch
// - opcode 04 clears write enable latch
// - opcode 05 streams status until deselect
// - opcode 15 streams configuration register
// - opcode 01 loads status, optional configuration
// - opcode 68 selects per-block protection
// - opcode 35 enters four-line, single-line only
// - opcode f5 leaves four-line, four-line only
// - opcode b0 suspends running program or erase
// - opcode 30 resumes suspended operation
// - opcode b9 enters deep sleep
// - opcode ab releases deep sleep
// - fast-boot write 17 four bytes, erase 18
// - four-line entry keeps quad enable bit
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/10ps
module sfc_cmd_decoder (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        CS_N,
  input  wire logic        SCLK,
  input  wire logic [3:0]  SIO_I,
  output logic      [3:0]  SIO_O,
  output logic      [3:0]  SIO_OE
);

  sfc_pkg::sfc_pins_t  pins_s1_ff;
  sfc_pkg::sfc_pins_t  pins_s2_ff;
  logic                sclk_d_ff;
  logic                cs_d_ff;
  logic                sclk_rise;
  logic                sclk_fall;
  logic                cs_rise;
  sfc_pkg::sfc_state_t state_ff;
  sfc_pkg::sfc_state_t nxt_state;
  logic [2:0]          rx_cnt_ff;
  logic [7:0]          rx_sh_ff;
  logic [7:0]          nxt_rx_sh;
  logic [7:0]          opcode_ff;
  logic [31:0]         data_sh_ff;
  logic [2:0]          data_cnt_ff;
  logic                op_done;
  logic                exec_ok;
  logic                no_data;
  logic                write_enable_latch_ff;
  logic [5:0]          sr_hi_ff;
  logic [7:0]          cfg_ff;
  logic [7:0]          burst_ff;
  logic                four_line_ff;
  logic                deep_sleep_ff;
  logic                block_protect_ff;
  logic                suspended_ff;
  logic                busy_ff;
  logic [7:0]          stat_byte;
  logic [7:0]          tx_byte;
  logic [7:0]          tx_sh_ff;
  logic [2:0]          tx_cnt_ff;
  logic [2:0]          tx_idx_ff;
  logic [7:0]          fb_rd_byte;
  logic [31:0]         fb_word;
  logic                fb_write;
  logic                fb_erase;
  logic                wb_req;
  logic [31:0]         rd_mux;
  sfc_pkg::sfc_mode_t  mode;
  logic [5:0]          wr_sr_val;
  logic [7:0]          wr_cfg_val;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers; only stage two and the delay stage feed logic
  always_ff @(posedge REF_CLK) begin : pin_sync
    if (RST) begin
      pins_s1_ff <= '{cs_n: 1'h1, sclk: 1'h0, sio: 4'h0};
      pins_s2_ff <= '{cs_n: 1'h1, sclk: 1'h0, sio: 4'h0};
      sclk_d_ff  <= 1'h0;
      cs_d_ff    <= 1'h1;
    end else begin
      pins_s1_ff <= '{cs_n: CS_N, sclk: SCLK, sio: SIO_I};
      pins_s2_ff <= pins_s1_ff;
      sclk_d_ff  <= pins_s2_ff.sclk;
      cs_d_ff    <= pins_s2_ff.cs_n;
    end
  end

  // edges of the link clock and end of frame
  assign sclk_rise = pins_s2_ff.sclk & ~sclk_d_ff & ~pins_s2_ff.cs_n;
  assign sclk_fall = ~pins_s2_ff.sclk & sclk_d_ff & ~pins_s2_ff.cs_n;
  assign cs_rise   = pins_s2_ff.cs_n & ~cs_d_ff;

  //////////////////////////////////////////////////////////////////////////
  // receive shift: one bit per edge on sio0, or a nibble on all four
  always_comb begin : rx_next
    nxt_rx_sh = four_line_ff ? {rx_sh_ff[3:0], pins_s2_ff.sio}
                             : {rx_sh_ff[6:0], pins_s2_ff.sio[0]};
  end

  assign op_done = sclk_rise && (state_ff == sfc_pkg::ST_OPCODE) &&
                   sfc_pkg::byte_done(rx_cnt_ff, four_line_ff);

  // opcode classification; deep sleep hears only the release opcode
  always_comb begin : classify
    if (deep_sleep_ff &&
        (nxt_rx_sh != sfc_pkg::DEEP_SLEEP_RELEASE_CMD)) begin
      nxt_state = sfc_pkg::ST_IGNORE;
    end else if (!sfc_pkg::cmd_defined(nxt_rx_sh, four_line_ff)) begin
      nxt_state = sfc_pkg::ST_IGNORE;
    end else if (sfc_pkg::cmd_is_read(nxt_rx_sh)) begin
      nxt_state = sfc_pkg::ST_DATA_OUT;
    end else begin
      nxt_state = sfc_pkg::ST_DATA_IN;
    end
  end

  // frame state; deselect returns everything to the opcode phase
  always_ff @(posedge REF_CLK) begin : link_fsm
    if (RST || pins_s2_ff.cs_n) begin
      state_ff    <= sfc_pkg::ST_OPCODE;
      rx_cnt_ff   <= 3'h0;
      rx_sh_ff    <= 8'h00;
      data_cnt_ff <= 3'h0;
    end else if (sclk_rise) begin
      rx_sh_ff <= nxt_rx_sh;
      if (sfc_pkg::byte_done(rx_cnt_ff, four_line_ff)) begin
        rx_cnt_ff <= 3'h0;
        if (state_ff == sfc_pkg::ST_OPCODE) begin
          state_ff <= nxt_state;
        end else if (state_ff == sfc_pkg::ST_DATA_IN &&
                     data_cnt_ff != 3'h7) begin
          data_cnt_ff <= data_cnt_ff + 3'h1;
        end
      end else begin
        rx_cnt_ff <= rx_cnt_ff + 3'h1;
      end
    end
  end

  // opcode and data bytes survive deselect so the end of frame can act
  always_ff @(posedge REF_CLK) begin : capture
    if (RST) begin
      opcode_ff  <= 8'h00;
      data_sh_ff <= 32'h0000_0000;
    end else if (sclk_rise && !pins_s2_ff.cs_n &&
                 sfc_pkg::byte_done(rx_cnt_ff, four_line_ff)) begin
      if (state_ff == sfc_pkg::ST_OPCODE) begin
        opcode_ff <= nxt_rx_sh;
      end else if (state_ff == sfc_pkg::ST_DATA_IN) begin
        data_sh_ff <= {data_sh_ff[23:0], nxt_rx_sh};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // commands act at deselect, and only on whole bytes
  assign exec_ok    = cs_rise && (state_ff == sfc_pkg::ST_DATA_IN) &&
                      (rx_cnt_ff == 3'h0);
  assign no_data    = (data_cnt_ff == 3'h0);
  assign wr_sr_val  = (data_cnt_ff == sfc_pkg::SR_CFG_BYTES) ?
                      data_sh_ff[15:10] : data_sh_ff[7:2];
  assign wr_cfg_val = data_sh_ff[7:0];

  // write enable latch
  always_ff @(posedge REF_CLK) begin : latch_reg
    if (RST) begin
      write_enable_latch_ff <= 1'h0;
    end else if (exec_ok && no_data) begin
      if (opcode_ff == sfc_pkg::WRITE_LATCH_SET_CMD) begin
        write_enable_latch_ff <= 1'h1;
      end else if (opcode_ff == sfc_pkg::WRITE_LATCH_CLEAR_CMD) begin
        write_enable_latch_ff <= 1'h0;
      end
    end
  end

  // status and configuration write; three or more bytes are refused
  always_ff @(posedge REF_CLK) begin : sr_cfg_reg
    if (RST) begin
      sr_hi_ff <= sfc_pkg::STATUS_HI_RST;
      cfg_ff   <= sfc_pkg::CONFIG_RST;
    end else if (exec_ok &&
                 opcode_ff == sfc_pkg::STATUS_CONFIG_WRITE_CMD) begin
      if (data_cnt_ff == sfc_pkg::SR_ONLY_BYTES) begin
        sr_hi_ff <= wr_sr_val;
      end else if (data_cnt_ff == sfc_pkg::SR_CFG_BYTES) begin
        sr_hi_ff <= wr_sr_val;
        cfg_ff   <= wr_cfg_val;
      end
    end
  end

  // mode flags: line width, deep sleep, protection scheme, burst length
  always_ff @(posedge REF_CLK) begin : mode_regs
    if (RST) begin
      four_line_ff     <= 1'h0;
      deep_sleep_ff    <= 1'h0;
      block_protect_ff <= 1'h0;
      burst_ff         <= sfc_pkg::BURST_RST;
    end else if (exec_ok) begin
      case (opcode_ff)
        sfc_pkg::BLOCK_PROTECT_SELECT_CMD:
          if (no_data) block_protect_ff <= 1'h1;
        // the quad enable bit lives in sr_hi_ff and is untouched here
        sfc_pkg::QUAD_CMD_MODE_ENTER:
          if (no_data) four_line_ff <= 1'h1;
        sfc_pkg::QUAD_CMD_MODE_EXIT:
          if (no_data) four_line_ff <= 1'h0;
        sfc_pkg::DEEP_SLEEP_ENTER_CMD:
          if (no_data) deep_sleep_ff <= 1'h1;
        sfc_pkg::DEEP_SLEEP_RELEASE_CMD:
          if (no_data) deep_sleep_ff <= 1'h0;
        sfc_pkg::BURST_LENGTH_SET_CMD:
          if (data_cnt_ff == 3'h1) burst_ff <= wr_cfg_val;
        default: ;
      endcase
    end
  end

  // suspend only makes sense while software reports an operation running
  always_ff @(posedge REF_CLK) begin : suspend_reg
    if (RST || !busy_ff) begin
      suspended_ff <= 1'h0;
    end else if (exec_ok && no_data &&
                 opcode_ff == sfc_pkg::SUSPEND_CMD) begin
      suspended_ff <= 1'h1;
    end else if (exec_ok && no_data &&
                 opcode_ff == sfc_pkg::RESUME_CMD) begin
      suspended_ff <= 1'h0;
    end
  end

  // fast-boot commit needs exactly four bytes, erase needs none
  assign fb_write = exec_ok && (opcode_ff == sfc_pkg::FASTBOOT_WRITE_CMD) &&
                    (data_cnt_ff == sfc_pkg::FB_WRITE_BYTES);
  assign fb_erase = exec_ok && (opcode_ff == sfc_pkg::FASTBOOT_ERASE_CMD) &&
                    no_data;

  sfc_fb_mem #(
    .NBYTES (sfc_pkg::FB_BYTES),
    .IDX_W  (2)
  ) u_fb_mem (
    .clk        (REF_CLK),
    .rst        (RST),
    .wr_en      (fb_write),
    .wr_word    (data_sh_ff),
    .erase      (fb_erase),
    .rd_idx     (tx_idx_ff[1:0]),
    .rd_byte_ff (fb_rd_byte),
    .word_ff    (fb_word)
  );

  //////////////////////////////////////////////////////////////////////////
  // read-out byte; status shows work in progress unless suspended
  assign stat_byte = {sr_hi_ff, write_enable_latch_ff,
                      busy_ff & ~suspended_ff};

  always_comb begin : tx_pick
    case (opcode_ff)
      sfc_pkg::STATUS_READ_CMD: tx_byte = stat_byte;
      sfc_pkg::CONFIG_READ_CMD: tx_byte = cfg_ff;
      sfc_pkg::FASTBOOT_READ_CMD:
        tx_byte = (tx_idx_ff < 3'h4) ? fb_rd_byte
                                     : sfc_pkg::IDLE_BYTE;
      default: tx_byte = 8'h00;
    endcase
  end

  // shift out on falling edges: sio1 on one line, a nibble on four
  always_ff @(posedge REF_CLK) begin : tx_shift
    if (RST || pins_s2_ff.cs_n) begin
      SIO_O     <= 4'h0;
      SIO_OE    <= 4'h0;
      tx_sh_ff  <= 8'h00;
      tx_cnt_ff <= 3'h0;
      tx_idx_ff <= 3'h0;
    end else if (sclk_fall && state_ff == sfc_pkg::ST_DATA_OUT) begin
      if (tx_cnt_ff == 3'h0) begin
        if (tx_idx_ff != 3'h7) tx_idx_ff <= tx_idx_ff + 3'h1;
        if (four_line_ff) begin
          SIO_O     <= tx_byte[7:4];
          SIO_OE    <= 4'hf;
          tx_sh_ff  <= {tx_byte[3:0], 4'h0};
          tx_cnt_ff <= 3'h1;
        end else begin
          SIO_O     <= {2'h0, tx_byte[7], 1'h0};
          SIO_OE    <= 4'h2;
          tx_sh_ff  <= {tx_byte[6:0], 1'h0};
          tx_cnt_ff <= 3'h7;
        end
      end else begin
        tx_cnt_ff <= tx_cnt_ff - 3'h1;
        if (four_line_ff) begin
          SIO_O    <= tx_sh_ff[7:4];
          tx_sh_ff <= {tx_sh_ff[3:0], 4'h0};
        end else begin
          SIO_O    <= {2'h0, tx_sh_ff[7], 1'h0};
          tx_sh_ff <= {tx_sh_ff[6:0], 1'h0};
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // wishbone slave: answer one cycle after the strobe, unmapped reads zero
  assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign mode   = '{block_protect: block_protect_ff,
                    suspended: suspended_ff,
                    deep_sleep: deep_sleep_ff,
                    four_line: four_line_ff};

  always_comb begin : rd_decode
    case ({WB_ADR_I[7:2], 2'h0})
      sfc_pkg::ADR_STATUS:   rd_mux = {24'h0, stat_byte};
      sfc_pkg::ADR_CONFIG:   rd_mux = {24'h0, cfg_ff};
      sfc_pkg::ADR_MODE:     rd_mux = {16'h0, burst_ff, 4'h0, mode};
      sfc_pkg::ADR_FASTBOOT: rd_mux = fb_word;
      sfc_pkg::ADR_CTRL:     rd_mux = {31'h0, busy_ff};
      default:               rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge REF_CLK) begin : wb_answer
    if (RST) begin
      WB_ACK_O <= 1'h0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK_O <= wb_req;
      if (wb_req) WB_DAT_O <= rd_mux;
    end
  end

  // software marks a program or erase in progress; drives the status bit
  always_ff @(posedge REF_CLK) begin : ctrl_reg
    if (RST) begin
      busy_ff <= 1'h0;
    end else if (wb_req && WB_WE_I && WB_SEL_I[0] &&
                 {WB_ADR_I[7:2], 2'h0} == sfc_pkg::ADR_CTRL) begin
      busy_ff <= WB_DAT_I[sfc_pkg::CTRL_BUSY_POS];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_simple(logic [7:0] op);
    exec_ok && no_data && (opcode_ff == op);
  endsequence

  sequence s_out_load(logic [7:0] op);
    sclk_fall && (state_ff == sfc_pkg::ST_DATA_OUT) &&
      (opcode_ff == op) && (tx_cnt_ff == 3'h0);
  endsequence

  latch_set_a: assert property (
    s_simple(sfc_pkg::WRITE_LATCH_SET_CMD) |=> write_enable_latch_ff)
    else $error("write enable latch not set");
  latch_clr_a: assert property (
    s_simple(sfc_pkg::WRITE_LATCH_CLEAR_CMD) |=> !write_enable_latch_ff)
    else $error("write enable latch not cleared");
  status_out_a: assert property (
    s_out_load(sfc_pkg::STATUS_READ_CMD) ##0 !four_line_ff
      |=> SIO_OE == 4'h2 && SIO_O[1] == $past(stat_byte[7]))
    else $error("status msb not driven on sio1");
  config_out_a: assert property (
    s_out_load(sfc_pkg::CONFIG_READ_CMD) ##0 four_line_ff
      |=> SIO_OE == 4'hf && SIO_O == cfg_ff[7:4])
    else $error("config high nibble not driven");
  sr_write_a: assert property (
    exec_ok && opcode_ff == sfc_pkg::STATUS_CONFIG_WRITE_CMD &&
      data_cnt_ff == sfc_pkg::SR_CFG_BYTES
      |=> sr_hi_ff == $past(wr_sr_val) && cfg_ff == $past(wr_cfg_val))
    else $error("status or config write lost");
  protect_sel_a: assert property (
    s_simple(sfc_pkg::BLOCK_PROTECT_SELECT_CMD) |=> block_protect_ff)
    else $error("block protection not selected");
  quad_enter_a: assert property (
    s_simple(sfc_pkg::QUAD_CMD_MODE_ENTER) |=> four_line_ff)
    else $error("four-line mode not entered");
  quad_exit_a: assert property (
    op_done && !four_line_ff && nxt_rx_sh == sfc_pkg::QUAD_CMD_MODE_EXIT
      |=> state_ff == sfc_pkg::ST_IGNORE)
    else $error("exit opcode accepted in single-line mode");
  suspend_hold_a: assert property (
    s_simple(sfc_pkg::SUSPEND_CMD) ##0 busy_ff
      |=> suspended_ff && !stat_byte[0])
    else $error("operation not suspended");
  resume_run_a: assert property (
    s_simple(sfc_pkg::RESUME_CMD) ##0 busy_ff |=> !suspended_ff)
    else $error("operation not resumed");
  sleep_deaf_a: assert property (
    op_done && deep_sleep_ff &&
      nxt_rx_sh != sfc_pkg::DEEP_SLEEP_RELEASE_CMD
      |=> state_ff == sfc_pkg::ST_IGNORE [*1] ##1 deep_sleep_ff)
    else $error("command heard in deep sleep");
  sleep_wake_a: assert property (
    s_simple(sfc_pkg::DEEP_SLEEP_RELEASE_CMD) |=> !deep_sleep_ff)
    else $error("deep sleep not released");
  fb_commit_a: assert property (
    fb_write |-> ##2 fb_word == $past(data_sh_ff, 2))
    else $error("fast-boot word not stored");
  qe_keep_a: assert property (
    $rose(four_line_ff) |-> $stable(sr_hi_ff))
    else $error("quad enable bit changed on mode entry");
  undef_ignore_a: assert property (
    op_done && !sfc_pkg::cmd_defined(nxt_rx_sh, four_line_ff)
      |=> state_ff == sfc_pkg::ST_IGNORE)
    else $error("undefined opcode not ignored");
  wb_ack_a: assert property (
    wb_req |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("bus answer not one cycle");

endmodule : sfc_cmd_decoder

// [tb/sfc_host_model.sv]
// serial host model: drives frames, samples read data
`timescale 1ns/10ps
module sfc_host_model (
  output sfc_pkg::sfc_pins_t pins,
  input  wire logic [3:0]    sio_o
);
  initial pins = '{cs_n: 1'b1, sclk: 1'b0, sio: 4'h0};

  // nb bytes sent msb first, then rb bytes read; clock idles low
  task automatic frame(input logic ql, input int nb, input logic [39:0] d,
                       input int rb, output logic [7:0] rx);
    int u;
    u = ql ? 2 : 8;
    rx = 8'h00;
    #7 pins.cs_n = 1'b0;
    for (int i = 0; i < (nb + rb) * u; i++) begin
      pins.sclk = 1'b0;
      if (i < nb * u)
        pins.sio = ql ? d[39-4*i -: 4] : {3'h0, d[39-i]};
      else
        pins.sio = ~pins.sio; // no host data while reading
      #32 pins.sclk = 1'b1;
      rx = ql ? {rx[3:0], sio_o} : {rx[6:0], sio_o[1]};
      #32;
    end
    pins.sclk = 1'b0;
    #32 pins.cs_n = 1'b1;
    pins.sio = ~pins.sio; // released lines show no stable value
    #120;
  endtask : frame
endmodule : sfc_host_model

// [tb/test_serial_flash_setting_cmd_decoder.sv]
// self-checking bench for the setting-command decoder
`timescale 1ns/10ps
module test_serial_flash_setting_cmd_decoder;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0]  adr = 8'h00, rx, b0, b1, c;
  logic [31:0] dat = 32'h0, q, rdat, w;
  logic [3:0]  sio_o, sio_oe;
  int          error_cnt = 0, samples_checked = 0;
  sfc_pkg::sfc_pins_t pins;

  always #2.5 ref_clk = ~ref_clk;

  sfc_cmd_decoder dut_u (.REF_CLK(ref_clk), .RST(rst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1),
    .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .CS_N(pins.cs_n),
    .SCLK(pins.sclk), .SIO_I(pins.sio), .SIO_O(sio_o), .SIO_OE(sio_oe));
  sfc_host_model host_u (.pins(pins), .sio_o(sio_o));

  ////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // status byte as the bus shows it, busy clear
  function automatic logic [31:0] st_of(input logic [7:0] h, input logic l);
    st_of = {24'h0, h[7:2], l, 1'b0};
  endfunction : st_of

  // one classic cycle; waits for ack under a bound
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    {cyc, stb, we, adr, dat} <= {2'b11, wr, a, d};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      summarize;
    end
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask : wb

  // start a quarter period past an edge so no pin moves on a clock edge
  task automatic fr(input logic ql, input int nb, input logic [39:0] d,
                    input int rb);
    @(posedge ref_clk);
    #1.25 host_u.frame(ql, nb, d, rb, rx);
  endtask : fr

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    error_cnt++;
    summarize;
  end

  // main sequence: random data through every command
  initial begin
    void'($urandom(19970));
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    wb(1, 8'h14, 32'hffffffff);
    wb(0, 8'h14, 0); chk(q, 0);
    wb(0, 8'h0c, 0); chk(q, 32'hffffffff);
    fr(0, 1, {8'h06, 32'h0}, 0); wb(0, 8'h00, 0); chk(q, 2);
    fr(0, 1, {8'h04, 32'h0}, 0); wb(0, 8'h00, 0); chk(q, 0);
    $display("done: latch");
    b0 = $urandom; b1 = $urandom; c = $urandom; w = $urandom;
    fr(0, 3, {8'h01, b0, b1, 16'h0}, 0);
    wb(0, 8'h00, 0); chk(q, st_of(b0, 0));
    wb(0, 8'h04, 0); chk(q, {24'h0, b1});
    fr(0, 1, {8'h05, 32'h0}, 2); chk(rx, st_of(b0, 0));
    chk(sio_oe, 0);
    fr(0, 1, {8'h15, 32'h0}, 1); chk(rx, b1);
    fr(0, 2, {8'h01, c, 24'h0}, 0); wb(0, 8'h04, 0);
    chk(q, {24'h0, b1}); wb(0, 8'h00, 0); chk(q, st_of(c, 0));
    $display("done: status");
    fr(0, 1, {8'h68, 32'h0}, 0);
    fr(0, 2, {8'hc0, b0, 24'h0}, 0);
    wb(0, 8'h08, 0); chk(q, {16'h0, b0, 8'h08});
    fr(0, 5, {8'h17, w}, 0); wb(0, 8'h0c, 0); chk(q, w);
    fr(0, 1, {8'h16, 32'h0}, 1); chk(rx, w[31:24]);
    fr(0, 1, {8'h18, 32'h0}, 0); wb(0, 8'h0c, 0);
    chk(q, 32'hffffffff);
    $display("done: fastboot");
    fr(0, 1, {8'hb0, 32'h0}, 0); wb(0, 8'h08, 0);
    chk(q, {16'h0, b0, 8'h08});
    wb(1, 8'h10, 1); fr(0, 1, {8'hb0, 32'h0}, 0);
    wb(0, 8'h08, 0); chk(q, {16'h0, b0, 8'h0c});
    fr(0, 1, {8'h30, 32'h0}, 0); wb(0, 8'h08, 0);
    chk(q, {16'h0, b0, 8'h08}); wb(1, 8'h10, 0);
    $display("done: suspend");
    fr(0, 1, {8'h35, 32'h0}, 0); wb(0, 8'h00, 0);
    chk(q, st_of(c, 0));
    fr(1, 1, {8'h18, 32'h0}, 0); fr(1, 1, {8'h06, 32'h0}, 0);
    fr(1, 1, {8'h05, 32'h0}, 1); chk(rx, st_of(c, 1));
    fr(1, 1, {8'h15, 32'h0}, 1); chk(rx, b1);
    fr(1, 1, {8'hf5, 32'h0}, 0); fr(0, 1, {8'hf5, 32'h0}, 0);
    wb(0, 8'h08, 0); chk(q, {16'h0, b0, 8'h08});
    $display("done: four-line");
    fr(0, 1, {8'hb9, 32'h0}, 0); fr(0, 1, {8'h04, 32'h0}, 0);
    wb(0, 8'h08, 0); chk(q, {16'h0, b0, 8'h0a});
    fr(0, 1, {8'hab, 32'h0}, 0); wb(0, 8'h00, 0);
    chk(q, st_of(c, 1));
    $display("done: sleep");
    summarize;
  end
endmodule : test_serial_flash_setting_cmd_decoder
